// [include/dssp_pkg.sv]
// ==========================================================
// discrete sensor spi port constants
package dssp_pkg;

    // ======================================================
    // widths
    localparam int DSSP_DATA_W = 8;
    localparam int DSSP_CFG_W  = 9;
    localparam int DSSP_WORD_W = 10;
    localparam int DSSP_FIFO_D = 4;
    localparam int DSSP_CNT_W  = 5;

    // ======================================================
    // field positions
    localparam int DSSP_CFG_ST_POS  = 8;
    localparam int DSSP_WORD_SEL_POS = 9;
    localparam int DSSP_SYNC_W      = 12;
    localparam int DSSP_SYNC_SEL    = 0;
    localparam int DSSP_SYNC_SI     = 1;
    localparam int DSSP_SYNC_SCK    = 2;
    localparam int DSSP_SYNC_CSN    = 3;
    localparam int DSSP_SYNC_SENSE  = 4;

    // ======================================================
    // reset values
    localparam logic [8:0]  DSSP_CFG_RST  = 9'h000;
    localparam logic [7:0]  DSSP_DATA_RST = 8'h00;
    localparam logic [11:0] DSSP_SYNC_RST = 12'h008;
    localparam logic [4:0]  DSSP_CNT_MAX  = 5'h1F;

    // ======================================================
    // serial clock limits
    localparam int DSSP_CLK_NS      = 8;
    localparam int DSSP_SCK_HALF_NS = 50;
    localparam int DSSP_SCK_HALF_CYC = DSSP_SCK_HALF_NS / DSSP_CLK_NS;

    // ======================================================
    // transfer state
    typedef enum logic [1:0] {
        DSSP_IDLE,
        DSSP_DATA,
        DSSP_CFG
    } dssp_state_t;

endpackage

// [include/dssp_stream_if.sv]
`timescale 1ns/1ps
// ==========================================================
// valid/ready word carrier
interface dssp_stream_if #(
    parameter int WIDTH = 10
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// [core/dssp_fifo.sv]
`timescale 1ns/1ps
// ==========================================================
// word fifo, flip-flop storage
module dssp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic srst_i,
    // streams
    dssp_stream_if.snk wr,
    dssp_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem_reg[rptr_reg];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // ======================================================
    // storage
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wptr_reg] <= wr.data;
        end
    end

    // ======================================================
    // pointers and fill level
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // dssp_fifo

// [core/dssp_port.sv]
`timescale 1ns/1ps
// Operation
// RULE_01 - slave only; transfers happen only while chip select is low
// RULE_02 - mode 0: input sampled and output advanced on rising clock
// RULE_03 - host keeps serial clock low when idle
// RULE_04 - bytes of eight bits, msb first, one bit per rising edge
// RULE_05 - chip select rising ends transfer and reinitialises the port
// RULE_06 - partial byte at chip select rise is still latched
// RULE_07 - serial output undriven whenever chip select is high
// RULE_08 - fully static; no lower bound on serial clock rate
// RULE_09 - register select high targets the sensor data register
// RULE_10 - chip select fall with data path captures sensors, shows bit eight
// RULE_11 - next seven rising edges shift out data bits seven to one
// RULE_12 - input shifts into data register, bit eight first, bit one last
// RULE_13 - eighth edge presents new bit eight for daisy chaining
// RULE_14 - host keeps chip select low across chained reads
// RULE_15 - register select low targets the configuration register
// RULE_16 - configuration path uses same timing, nine bits long
// RULE_17 - host aligns configuration bits to the nine-bit length
// RULE_18 - full duplex: one bit in and one out per clock
// RULE_19 - selftest bit shifted first, then eight channel mode bits
// RULE_20 - selftest forces each channel to its mode bit value
// RULE_21 - configuration transfer shifts out previous contents, selftest first
module dssp_port
    import dssp_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   srst_i,
    // spi pins
    input  wire logic                   cs_n_i,
    input  wire logic                   sck_i,
    input  wire logic                   si_i,
    input  wire logic                   reg_sel_i,
    output logic                        so_o,
    output logic                        so_oe_o,
    // sensor side
    input  wire logic [DSSP_DATA_W-1:0] discrete_input_channel_i,
    output logic [DSSP_DATA_W-1:0]      channel_mode_bit_o,
    output logic                        selftest_enable_bit_o,
    output logic                        cfg_written_o,
    // received word stream
    output logic                        rx_valid_o,
    output logic [DSSP_WORD_W-1:0]      rx_data_o,
    input  wire logic                   rx_ready_i,
    output logic                        rx_overrun_o
);

    // ======================================================
    // declarations
    logic [DSSP_SYNC_W-1:0] sync1_reg;
    logic [DSSP_SYNC_W-1:0] sync2_reg;
    logic                   sck_prev_reg;
    logic                   csn_prev_reg;
    dssp_state_t            state_reg;
    logic [DSSP_DATA_W-1:0] data_reg;
    logic [DSSP_CFG_W-1:0]  cfg_shift_reg;
    logic [DSSP_CFG_W-1:0]  cfg_reg;
    logic [DSSP_CNT_W-1:0]  bit_cnt_reg;
    logic                   so_reg;
    logic                   so_oe_reg;
    logic                   cfg_written_reg;
    logic                   push_valid_reg;
    logic [DSSP_WORD_W-1:0] push_data_reg;
    logic                   overrun_reg;
    logic                   out_valid_reg;
    logic [DSSP_WORD_W-1:0] out_data_reg;
    logic                   csn_s;
    logic                   sck_s;
    logic                   si_s;
    logic                   sel_s;
    logic [DSSP_DATA_W-1:0] sense_s;
    logic                   cs_fall;
    logic                   cs_rise;
    logic                   sck_rise;
    logic [DSSP_DATA_W-1:0] sensor_val;
    logic [DSSP_DATA_W-1:0] data_next;
    logic [DSSP_CFG_W-1:0]  cfg_shift_next;
    logic                   out_load;

    dssp_stream_if #(.WIDTH(DSSP_WORD_W)) fifo_wr ();
    dssp_stream_if #(.WIDTH(DSSP_WORD_W)) fifo_rd ();

    // ======================================================
    // pin synchronisers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sync1_reg <= DSSP_SYNC_RST;
            sync2_reg <= DSSP_SYNC_RST;
        end else begin
            sync1_reg <= {discrete_input_channel_i, cs_n_i, sck_i, si_i,
                          reg_sel_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign csn_s   = sync2_reg[DSSP_SYNC_CSN];
    assign sck_s   = sync2_reg[DSSP_SYNC_SCK];
    assign si_s    = sync2_reg[DSSP_SYNC_SI];
    assign sel_s   = sync2_reg[DSSP_SYNC_SEL];
    assign sense_s = sync2_reg[DSSP_SYNC_SENSE +: DSSP_DATA_W];

    // ======================================================
    // edge detection
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sck_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s; // RULE_02
            csn_prev_reg <= csn_s;
        end
    end

    assign cs_fall  = csn_prev_reg && !csn_s;
    assign cs_rise  = !csn_prev_reg && csn_s;
    // clock edges only count while selected; idle clock is ignored
    assign sck_rise = sck_s && !sck_prev_reg && !csn_s; // RULE_01 RULE_03

    // ======================================================
    // sensor value, selftest override
    assign sensor_val = cfg_reg[DSSP_CFG_ST_POS] ?
                        cfg_reg[DSSP_DATA_W-1:0] : sense_s; // RULE_20

    // ======================================================
    // shift paths, msb out, new bit in at lsb
    assign data_next      = {data_reg[DSSP_DATA_W-2:0], si_s}; // RULE_12
    assign cfg_shift_next = {cfg_shift_reg[DSSP_CFG_W-2:0], si_s}; // RULE_16

    // ======================================================
    // transfer state
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= DSSP_IDLE;
        end else if (cs_rise) begin
            state_reg <= DSSP_IDLE; // RULE_05
        end else if (cs_fall) begin
            state_reg <= sel_s ? DSSP_DATA : DSSP_CFG; // RULE_09 RULE_15
        end
    end

    // ======================================================
    // bit counter, saturating, static
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bit_cnt_reg <= '0;
        end else if (cs_fall || cs_rise) begin
            bit_cnt_reg <= '0; // RULE_05
        end else if (sck_rise && bit_cnt_reg != DSSP_CNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1; // RULE_08
        end
    end

    // ======================================================
    // data register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_reg <= DSSP_DATA_RST;
        end else if (cs_fall && sel_s) begin
            data_reg <= sensor_val; // RULE_10
        end else if (sck_rise && state_reg == DSSP_DATA) begin
            data_reg <= data_next; // RULE_04 RULE_12
        end
    end

    // ======================================================
    // configuration shift path and register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cfg_shift_reg <= DSSP_CFG_RST;
        end else if (cs_fall && !sel_s) begin
            cfg_shift_reg <= cfg_reg; // RULE_21
        end else if (sck_rise && state_reg == DSSP_CFG) begin
            cfg_shift_reg <= cfg_shift_next; // RULE_19
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cfg_reg         <= DSSP_CFG_RST;
            cfg_written_reg <= 1'b0;
        end else if (cs_rise && state_reg == DSSP_CFG) begin
            cfg_reg         <= cfg_shift_reg; // RULE_06 RULE_16
            cfg_written_reg <= 1'b1;
        end
    end

    // ======================================================
    // serial output, full duplex
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            so_reg <= 1'b0;
        end else if (cs_fall) begin
            so_reg <= sel_s ? sensor_val[DSSP_DATA_W-1] :
                              cfg_reg[DSSP_CFG_W-1]; // RULE_10 RULE_21
        end else if (sck_rise) begin
            unique case (state_reg)
                DSSP_DATA: begin
                    so_reg <= data_next[DSSP_DATA_W-1]; // RULE_11 RULE_13
                end
                DSSP_CFG:  so_reg <= cfg_shift_next[DSSP_CFG_W-1]; // RULE_18
                DSSP_IDLE: so_reg <= so_reg;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= !csn_s && !cs_rise; // RULE_07
        end
    end

    // ======================================================
    // completed transfer word toward the fifo
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            push_valid_reg <= 1'b0;
            push_data_reg  <= '0;
            overrun_reg    <= 1'b0;
        end else begin
            if (cs_rise && state_reg != DSSP_IDLE) begin
                push_valid_reg <= 1'b1;
                push_data_reg  <= (state_reg == DSSP_CFG) ?
                                  {1'b0, cfg_shift_reg} :
                                  {1'b1, 1'b0, data_reg}; // RULE_06
                overrun_reg    <= push_valid_reg && !fifo_wr.ready;
            end else if (fifo_wr.ready) begin
                push_valid_reg <= 1'b0;
            end
        end
    end

    assign fifo_wr.valid = push_valid_reg;
    assign fifo_wr.data  = push_data_reg;

    dssp_fifo #(
        .WIDTH (DSSP_WORD_W),
        .DEPTH (DSSP_FIFO_D)
    ) u_fifo (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .wr     (fifo_wr.snk),
        .rd     (fifo_rd.src)
    );

    // ======================================================
    // registered output stage
    assign out_load      = !out_valid_reg || rx_ready_i;
    assign fifo_rd.ready = out_load;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else if (out_load) begin
            out_valid_reg <= fifo_rd.valid;
            if (fifo_rd.valid) begin
                out_data_reg <= fifo_rd.data;
            end
        end
    end

    // ======================================================
    // outputs
    assign so_o                  = so_reg;
    assign so_oe_o               = so_oe_reg;
    assign channel_mode_bit_o    = cfg_reg[DSSP_DATA_W-1:0];
    assign selftest_enable_bit_o = cfg_reg[DSSP_CFG_ST_POS];
    assign cfg_written_o         = cfg_written_reg;
    assign rx_valid_o            = out_valid_reg;
    assign rx_data_o             = out_data_reg;
    assign rx_overrun_o          = overrun_reg;

endmodule // dssp_port

// [sim/dssp_port_sva.sv]
`timescale 1ns/1ps
// ======================================================
// port checker
module dssp_port_sva
    import dssp_pkg::*;
(
    // clock and reset
    input wire logic                   mclk_i,
    input wire logic                   srst_i,
    // spi pins
    input wire logic                   cs_n_i,
    input wire logic                   sck_i,
    input wire logic                   so_o,
    input wire logic                   so_oe_o,
    // config and stream
    input wire logic [DSSP_DATA_W-1:0] channel_mode_bit_o,
    input wire logic                   selftest_enable_bit_o,
    input wire logic                   rx_valid_o,
    input wire logic [DSSP_WORD_W-1:0] rx_data_o,
    input wire logic                   rx_ready_i
);
    logic       sck_q;
    logic       cs_q;
    logic [3:0] quiet_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ======================================================
    // cycles since last pin change
    always_ff @(posedge mclk_i) begin
        sck_q <= sck_i;
        cs_q  <= cs_n_i;
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i || sck_i != sck_q || cs_n_i != cs_q) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end

    sequence cs_fall_s;
        $fell(cs_n_i);
    endsequence
    sequence cs_idle_s;
        cs_n_i [*8];
    endsequence

    // ======================================================
    // assertions
    oe_on_a: assert property (cs_fall_s |-> ##[2:5] so_oe_o)
        else $error("output not driven after select fall");
    oe_off_a: assert property ($rose(cs_n_i) |-> ##[2:5] !so_oe_o)
        else $error("output still driven after select rise");
    oe_idle_a: assert property (cs_idle_s |-> !so_oe_o)
        else $error("output driven while deselected");
    oe_cause_a: assert property (
        $rose(so_oe_o) |-> !cs_n_i && !$past(cs_n_i, 2))
        else $error("output driven without select");
    oe_hold_a: assert property (
        (!cs_n_i) [*4] ##0 so_oe_o |=> so_oe_o)
        else $error("output dropped during transfer");
    so_edge_a: assert property (
        $changed(so_o) |-> quiet_reg <= 4'h6)
        else $error("serial output moved without pin edge");
    so_still_a: assert property (cs_idle_s |-> $stable(so_o))
        else $error("serial output moved while deselected");
    cfg_hold_a: assert property (
        cs_idle_s |-> $stable({selftest_enable_bit_o, channel_mode_bit_o}))
        else $error("config changed while deselected");
    rx_stand_a: assert property (
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("word dropped before taken");
endmodule // dssp_port_sva

bind dssp_port dssp_port_sva u_sva (
    .mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .so_o(so_o), .so_oe_o(so_oe_o),
    .channel_mode_bit_o(channel_mode_bit_o),
    .selftest_enable_bit_o(selftest_enable_bit_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_ready_i)
);

// [sim/dssp_host_model.sv]
`timescale 1ns/1ps
// ======================================================
// host spi master, 160 ns serial clock
module dssp_host_model (
    input  wire logic mclk_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      sel_o
);
    localparam int HALF = 10;

    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
        sel_o  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // n bits msb first, n+1 output samples
    task automatic xfer(input logic sel, input int n,
                        input logic [15:0] din, output logic [16:0] dout);
        dout = '0;
        @(posedge mclk_i);
        sel_o <= sel;
        wait_cyc(HALF);
        cs_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si_o <= din[i];
            wait_cyc(HALF);
            dout = {dout[15:0], so_i};
            sck_o <= 1'b1;
            wait_cyc(HALF);
            sck_o <= 1'b0;
        end
        wait_cyc(HALF);
        dout = {dout[15:0], so_i};
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        wait_cyc(HALF);
    endtask
endmodule // dssp_host_model

// [sim/dssp_port_tb.sv]
`timescale 1ns/1ps
module dssp_port_tb
    import dssp_pkg::*;
;
    // ======================================================
    // signals
    logic                   mclk_i, srst_i, rx_ready_i;
    logic                   cs_n, sck, si, sel, so, so_oe;
    logic                   st_bit, cfg_wr, rx_valid, overrun;
    logic [DSSP_DATA_W-1:0] sense, mode;
    logic [DSSP_WORD_W-1:0] rx_data;
    logic [DSSP_WORD_W-1:0] got[$];
    logic [16:0]            dout;
    wire                    so_w;
    int                     mismatches, total_checks;

    assign so_w = so_oe ? so : 1'bz;
    always #4 mclk_i = ~mclk_i;

    dssp_port DUT (
        .mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .reg_sel_i(sel), .so_o(so), .so_oe_o(so_oe),
        .discrete_input_channel_i(sense), .channel_mode_bit_o(mode),
        .selftest_enable_bit_o(st_bit), .cfg_written_o(cfg_wr),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready_i), .rx_overrun_o(overrun)
    );
    dssp_host_model u_host (
        .mclk_i(mclk_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si), .sel_o(sel)
    );

    always @(negedge mclk_i) begin
        if (rx_valid === 1'b1 && rx_ready_i === 1'b1) begin
            got.push_back(rx_data);
        end
    end

    // ======================================================
    // helpers
    task automatic check(input string what, input logic [16:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic go(input logic s, input int n, input logic [15:0] d,
                      input logic [7:0] sns);
        sense <= sns;
        u_host.xfer(s, n, d, dout);
    endtask
    task automatic take(input logic [9:0] exp);
        int n;
        n = 0;
        while (got.size() == 0 && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        if (got.size() == 0) begin
            mismatches++;
            test_done();
        end else begin
            check("rx word", {7'h0, got.pop_front()}, {7'h0, exp});
        end
    endtask

    // ======================================================
    // scenarios
    task automatic t_reset();
        logic [12:0] v;
        v = {so_oe, st_bit, mode, cfg_wr, rx_valid, overrun};
        check("reset", {4'h0, v}, 17'h0);
    endtask
    task automatic t_data();
        go(1'b1, 16, 16'hF00D, 8'h5A);
        check("chain out", dout, {8'h5A, 8'hF0, 1'b0});
        check("released", {16'h0, so_w}, {16'h0, 1'bz});
        take(10'h20D);
    endtask
    task automatic t_cfg();
        go(1'b0, 9, 16'h01A5, 8'h0F);
        check("cfg old", {7'h0, dout[9:0]}, 17'h001);
        check("cfg new", {7'h0, cfg_wr, st_bit, mode}, 17'h3A5);
        take(10'h1A5);
        go(1'b1, 8, 16'h0000, 8'h0F);
        check("forced", {8'h0, dout[8:0]}, 17'h14A);
        take(10'h200);
        go(1'b0, 16, 16'h0055, 8'h0F);
        check("cfg pad", dout, 17'h1A500);
        check("cfg pad new", {8'h0, st_bit, mode}, 17'h055);
        take(10'h055);
    endtask
    task automatic t_part();
        go(1'b1, 5, 16'h0016, 8'hC3);
        check("part out", {11'h0, dout[5:0]}, 17'h30);
        take(10'h276);
    endtask
    task automatic t_fifo();
        rx_ready_i <= 1'b0;
        for (int k = 1; k <= 7; k++) go(1'b1, 1, 16'h0001, 8'(k));
        check("overrun", {16'h0, overrun}, 17'h1);
        rx_ready_i <= 1'b1;
        for (int k = 1; k <= 5; k++) take(10'h201 | 10'(k << 1));
        take(10'h20F);
    endtask

    initial begin
        mclk_i = 1'b0;
        srst_i = 1'b1;
        rx_ready_i = 1'b1;
        sense = 8'h00;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        t_reset();
        t_data();
        t_cfg();
        t_part();
        t_fifo();
        test_done();
    end
endmodule // dssp_port_tb
